// ---- src/pwl_write_lock.sv ----
// Purpose: guarded pwm output-control and fault-limit register bank
// Assumes: access bus synchronous to clk_in, one access per cycle
// Notes: fuse level is taken once, in the first cycle after reset
`timescale 1ns/1ps
module pwl_write_lock import pwl_pkg::*; (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire pwl_acc_t acc_in,
	input wire logic [15:0] osc_cfg_word_in,
	output logic [NUM_GEN-1:0][15:0] ctl_regs_out,
	output logic [NUM_GEN-1:0][15:0] flt_regs_out,
	output logic [15:0] rd_data_out,
	output logic rd_valid_out,
	output logic lock_on_out,
	output logic unlocked_out,
	output logic refused_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic fuse_r;
	logic fuse_nxt;
	logic fuse_seen_r;
	logic fuse_seen_nxt;
	logic [NUM_GEN-1:0][15:0] ctl_r;
	logic [NUM_GEN-1:0][15:0] ctl_nxt;
	logic [NUM_GEN-1:0][15:0] flt_r;
	logic [NUM_GEN-1:0][15:0] flt_nxt;
	logic [15:0] rd_data_r;
	logic [15:0] rd_data_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic refused_r;
	logic refused_nxt;
	pwl_dec_t dec;
	logic key_hit;
	logic key_wr;
	logic guard_wr;
	logic armed;
	logic allow;

	// ----------------------------------------------------------------
	// lock fuse capture
	// ----------------------------------------------------------------
	// reset holds the locked default; the level is sampled after release
	always_comb begin
		fuse_nxt = fuse_r;
		fuse_seen_nxt = fuse_seen_r;
		if (!fuse_seen_r) begin
			fuse_nxt = osc_cfg_word_in[FUSE_BIT]; // RULE2
			fuse_seen_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			fuse_r <= FUSE_RESET; // RULE2
			fuse_seen_r <= 1'b0;
		end else begin
			fuse_r <= fuse_nxt;
			fuse_seen_r <= fuse_seen_nxt;
		end
	end

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	assign dec = pwl_decode(acc_in.addr);
	assign key_hit = acc_in.valid && acc_in.addr == KEY_ADDR;
	assign key_wr = key_hit && acc_in.write;
	assign guard_wr = acc_in.valid && acc_in.write && dec.hit;

	pwl_key_seq u_key_seq (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.acc_valid_in(acc_in.valid),
		.key_wr_in(key_wr),
		.key_data_in(acc_in.wdata),
		.armed_out(armed)
	);

	// fuse cleared means no key needed at all
	assign allow = !fuse_r || armed; // RULE3

	// ----------------------------------------------------------------
	// guarded register bank
	// ----------------------------------------------------------------
	always_comb begin
		ctl_nxt = ctl_r;
		flt_nxt = flt_r;
		refused_nxt = 1'b0;
		if (guard_wr) begin
			if (allow) begin
				if (dec.is_flt) begin
					flt_nxt[dec.idx] = acc_in.wdata; // RULE1
				end else begin
					ctl_nxt[dec.idx] = acc_in.wdata; // RULE1
				end
			end else begin
				// dropped silently on the bus, flagged for debug only
				refused_nxt = 1'b1; // RULE8
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ctl_r <= {NUM_GEN{REG_RESET}};
			flt_r <= {NUM_GEN{REG_RESET}};
			refused_r <= 1'b0;
		end else begin
			ctl_r <= ctl_nxt;
			flt_r <= flt_nxt;
			refused_r <= refused_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// key register is write only and reads back zero
	always_comb begin
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		if (acc_in.valid && !acc_in.write && (dec.hit || key_hit)) begin
			rd_valid_nxt = 1'b1;
			if (!dec.hit) begin
				rd_data_nxt = KEY_READ;
			end else if (dec.is_flt) begin
				rd_data_nxt = flt_r[dec.idx];
			end else begin
				rd_data_nxt = ctl_r[dec.idx];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			rd_data_r <= REG_RESET;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ctl_regs_out = ctl_r;
	assign flt_regs_out = flt_r;
	assign rd_data_out = rd_data_r;
	assign rd_valid_out = rd_valid_r;
	assign lock_on_out = fuse_r;
	assign unlocked_out = armed;
	assign refused_out = refused_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	locked_drop_a: assert property (@(posedge clk_in) // RULE8
		disable iff (!nrst_in) guard_wr && fuse_r && !armed |=>
		refused_out && $stable(ctl_r) && $stable(flt_r))
		else $error("unkeyed guarded write changed a register");

	fuse_open_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		guard_wr && !fuse_r |=> !refused_out) // RULE3
		else $error("write refused with lock fuse cleared");

	fuse_default_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!fuse_seen_r |-> fuse_r) // RULE2
		else $error("lock not on before fuse sampled");

	fuse_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		fuse_seen_r |=> $stable(fuse_r)) // RULE2
		else $error("fuse level changed after capture");

	// only a sequence started from idle: a repeated first key cancels
	key_write_a: assert property (@(posedge clk_in) // RULE5
		disable iff (!nrst_in) u_key_seq.state_r == SEQ_IDLE &&
		key_wr && acc_in.wdata == KEY_FIRST ##1
		key_wr && acc_in.wdata == KEY_SECOND ##1 guard_wr |=> !refused_out)
		else $error("keyed guarded write refused");

	one_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		guard_wr && armed && fuse_r ##1 guard_wr |=> refused_out) // RULE7
		else $error("second write passed on one unlock");

	guard_all_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!guard_wr |=> $stable(ctl_r) && $stable(flt_r)) // RULE1
		else $error("guarded register changed without a write");

endmodule

// ---- common/pwl_pkg.sv ----
// Purpose: shared constants and types for the pwm register write lock
// Assumes: 16-bit special function register space, byte addressed
// Notes: guarded register addresses are local choices, see hand-over
//
// How it works
// [RULE1] all pwm output-control and fault-limit registers are write guarded
// [RULE2] lock fuse is bit 6 of the oscillator config word, 1 locks
// [RULE3] fuse at 0 lets guarded writes through with no key sequence
// [RULE4] software writes key register with 0xABCD then 0x4321 back to back
// [RULE5] guarded write is honoured only as the first access after key two
// [RULE6] software makes no other register access inside the sequence
// [RULE7] each unlock allows one guarded write, then the lock closes again
// [RULE8] unkeyed guarded writes are dropped; wrong key or access cancels
package pwl_pkg;

	// ----------------------------------------------------------------
	// sizes, keys and fuse
	// ----------------------------------------------------------------
	localparam int NUM_GEN = 3;
	localparam logic [15:0] KEY_FIRST = 16'hABCD;
	localparam logic [15:0] KEY_SECOND = 16'h4321;
	localparam int FUSE_BIT = 6;
	localparam logic FUSE_RESET = 1'b1;

	// ----------------------------------------------------------------
	// address map and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] KEY_ADDR = 16'h0C1E;
	localparam logic [15:0] CTL_BASE = 16'h0C20;
	localparam logic [15:0] FLT_BASE = 16'h0C40;
	localparam logic [15:0] REG_STRIDE = 16'h0002;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] KEY_READ = 16'h0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pwl_acc_t;

	typedef struct packed {
		logic hit;
		logic is_flt;
		logic [1:0] idx;
	} pwl_dec_t;

	typedef enum {SEQ_IDLE, SEQ_FIRST, SEQ_ARMED} pwl_seq_t;

	function automatic pwl_dec_t pwl_decode(input logic [15:0] addr);
		pwl_dec_t d;
		d = '0;
		for (int g = 0; g < NUM_GEN; g++) begin
			if (addr == CTL_BASE + REG_STRIDE * 16'(g)) begin
				d.hit = 1'b1;
				d.idx = 2'(g);
			end
			if (addr == FLT_BASE + REG_STRIDE * 16'(g)) begin
				d.hit = 1'b1;
				d.is_flt = 1'b1;
				d.idx = 2'(g);
			end
		end
		return d;
	endfunction

endpackage

// ---- src/pwl_key_seq.sv ----
// Purpose: key sequence tracker that arms one guarded write
// Assumes: one access per cycle at most, qualified by acc_valid_in
// Notes: any access other than the expected key write cancels
`timescale 1ns/1ps
module pwl_key_seq import pwl_pkg::*; (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic acc_valid_in,
	input wire logic key_wr_in,
	input wire logic [15:0] key_data_in,
	output logic armed_out
);

	pwl_seq_t state_r;
	pwl_seq_t state_nxt;
	logic armed_r;
	logic armed_nxt;

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (acc_valid_in) begin
			unique case (state_r)
				SEQ_IDLE: begin
					if (key_wr_in && key_data_in == KEY_FIRST) begin
						state_nxt = SEQ_FIRST;
					end
				end
				SEQ_FIRST: begin
					// anything but the second key drops back
					if (key_wr_in && key_data_in == KEY_SECOND) begin
						state_nxt = SEQ_ARMED; // RULE5
					end else begin
						state_nxt = SEQ_IDLE; // RULE8
					end
				end
				SEQ_ARMED: begin
					// consumed by the very next access, whatever it is
					state_nxt = SEQ_IDLE; // RULE7
				end
			endcase
		end
		armed_nxt = (state_nxt == SEQ_ARMED);
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_r <= SEQ_IDLE;
			armed_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			armed_r <= armed_nxt;
		end
	end

	assign armed_out = armed_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	key_arms_a: assert property (@(posedge clk_in) // RULE5
		disable iff (!nrst_in) state_r == SEQ_FIRST && acc_valid_in &&
		key_wr_in && key_data_in == KEY_SECOND |=> armed_out)
		else $error("second key did not arm");

	bad_key_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE8
		state_r == SEQ_FIRST && acc_valid_in &&
		!(key_wr_in && key_data_in == KEY_SECOND) |=> state_r == SEQ_IDLE)
		else $error("partial unlock not cancelled");

	arm_once_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE7
		armed_out && acc_valid_in |=> !armed_out)
		else $error("arm outlived one access");

endmodule

// ---- tb/test_pwl_write_lock.sv ----
// Purpose: self-checking bench for the pwm register write lock
// Assumes: inputs driven at the falling edge, outputs read there too
// Notes: checks use reads back, refusal pulses and register outputs
`timescale 1ns/1ps
module test_pwl_write_lock;
	import pwl_pkg::*;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	pwl_acc_t acc = '0;
	logic [15:0] osc = 16'h0000;
	logic [NUM_GEN-1:0][15:0] ctl_q, flt_q;
	logic [15:0] rd_data_out;
	logic rd_valid_out, lock_on_out, unlocked_out, refused_out;
	logic [15:0] rdq[$];
	logic refq[$];
	logic [15:0] exp_r[6];
	int miscompares = 0;
	int compares = 0;

	always #25 clk_in = ~clk_in;

	pwl_write_lock i_pwl_write_lock (.clk_in(clk_in), .nrst_in(nrst_in),
		.acc_in(acc), .osc_cfg_word_in(osc), .ctl_regs_out(ctl_q),
		.flt_regs_out(flt_q), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .lock_on_out(lock_on_out),
		.unlocked_out(unlocked_out), .refused_out(refused_out));

	// ----------------------------------------------------------------
	// compare and access tasks
	// ----------------------------------------------------------------
	task automatic chk16(input logic [15:0] got, input logic [15:0] e);
		compares++;
		if (got !== e) begin
			miscompares++;
			$display("MISMATCH %0t value %h expected %h", $time, got, e);
		end
	endtask

	task automatic chk1(input logic got, input logic e);
		compares++;
		if (got !== e) begin
			miscompares++;
			$display("MISMATCH %0t flag %b expected %b", $time, got, e);
		end
	endtask

	function automatic logic [15:0] adr(input int i);
		return i < 3 ? CTL_BASE + REG_STRIDE * 16'(i)
			: FLT_BASE + REG_STRIDE * 16'(i - 3);
	endfunction

	function automatic logic [15:0] got_r(input int i);
		return i < 3 ? ctl_q[i] : flt_q[i - 3];
	endfunction

	task automatic put(input logic w, input logic [15:0] a, d);
		acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(negedge clk_in);
	endtask

	task automatic idle();
		acc.valid = 1'b0;
		@(negedge clk_in);
	endtask

	task automatic rd(input int i);
		rdq.push_back(exp_r[i]);
		put(1'b0, adr(i), 16'h0000);
	endtask

	// ok=0: refusal expected, shadow left alone
	task automatic gw(input int i, input logic ok);
		logic [15:0] d;
		d = 16'($urandom());
		if (ok)
			exp_r[i] = d;
		else
			refq.push_back(1'b1);
		put(1'b1, adr(i), d);
		chk16(got_r(i), exp_r[i]);
	endtask

	task automatic unlock(input logic gap);
		put(1'b1, KEY_ADDR, KEY_FIRST);
		if (gap)
			idle();
		put(1'b1, KEY_ADDR, KEY_SECOND);
		chk1(unlocked_out, 1'b1);
	endtask

	task automatic rst(input logic fuse);
		logic [15:0] w;
		// one quiet cycle so the last result is seen before reset
		idle();
		nrst_in = 1'b0;
		w = 16'($urandom());
		w[FUSE_BIT] = fuse;
		osc = w;
		repeat (20) @(negedge clk_in);
		nrst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk1(lock_on_out, fuse);
		for (int i = 0; i < 6; i++) exp_r[i] = REG_RESET;
	endtask

	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// monitor: every result takes the oldest note
	// ----------------------------------------------------------------
	always @(negedge clk_in) begin
		if (nrst_in === 1'b1 && rd_valid_out === 1'b1) begin
			if (rdq.size() == 0)
				chk1(1'b1, 1'b0);
			else
				chk16(rd_data_out, rdq.pop_front());
		end
		if (nrst_in === 1'b1 && refused_out === 1'b1) begin
			if (refq.size() == 0)
				chk1(1'b1, 1'b0);
			else
				void'(refq.pop_front());
		end
	end

	initial begin
		#(2000 * 50);
		miscompares++;
		close_out();
	end

	initial begin
		void'($urandom(5));
		rst(1'b1);
		for (int i = 0; i < 6; i++) rd(i);
		for (int i = 0; i < 6; i++) begin
			gw(i, 1'b0);
			rd(i);
		end
		$display("test unkeyed writes done");
		for (int i = 0; i < 6; i++) begin
			unlock(i[0]);
			gw(i, 1'b1);
			chk1(unlocked_out, 1'b0);
			gw(i, 1'b0);
			rd(i);
		end
		$display("test unlock each register done");
		put(1'b1, KEY_ADDR, KEY_FIRST);
		put(1'b1, KEY_ADDR, 16'h1234);
		gw(0, 1'b0);
		put(1'b1, KEY_ADDR, KEY_FIRST);
		rd(1);
		put(1'b1, KEY_ADDR, KEY_SECOND);
		gw(1, 1'b0);
		unlock(1'b0);
		rdq.push_back(KEY_READ);
		put(1'b0, KEY_ADDR, 16'h0000);
		gw(3, 1'b0);
		put(1'b1, KEY_ADDR, KEY_FIRST);
		put(1'b1, KEY_ADDR, KEY_FIRST);
		put(1'b1, KEY_ADDR, KEY_SECOND);
		gw(4, 1'b0);
		put(1'b0, 16'h0C30, 16'h0000);
		for (int i = 0; i < 6; i++) rd(i);
		$display("test cancelled sequences done");
		rst(1'b0);
		for (int i = 0; i < 6; i++) begin
			gw(i, 1'b1);
			rd(i);
		end
		repeat (3) idle();
		chk16(16'(rdq.size() + refq.size()), 16'h0000);
		$display("test fuse open done");
		close_out();
	end
endmodule
